// File: ltfac_pkg.sv
// constants, command codes and field layout for the laser transmitter controller
// assumes a 20 MHz clock and a host command port already decoded from the serial bus
package ltfac_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int CONV_TIME_US = 1000;
  localparam int LOCK_WIN_US = 25000;
  localparam int CONV_CYC = (CLK_HZ / 1000000) * CONV_TIME_US;
  localparam int LOCK_CYC = (CLK_HZ / 1000000) * LOCK_WIN_US;

  localparam int ADC_W = 10;
  localparam int BOOST_W = 5;

  // command codes of the host register set
  localparam logic [7:0] CMD_CTRL = 8'h00;
  localparam logic [7:0] CMD_FLT_CFG = 8'h01;
  localparam logic [7:0] CMD_FLT_STAT = 8'h02;
  localparam logic [7:0] CMD_BOOST = 8'h03;
  localparam logic [7:0] CMD_TEMP = 8'h04;
  localparam logic [7:0] CMD_MOD_RES = 8'h05;
  localparam logic [7:0] CMD_SLOT3 = 8'h06;
  localparam logic [7:0] CMD_USER = 8'h07;
  localparam logic [7:0] CMD_SRC_DAC = 8'h08;
  localparam logic [7:0] CMD_MOD_DAC = 8'h09;

  // control register bits
  localparam int B_SOFT_EN = 0;
  localparam int B_AUTO_SD = 1;
  localparam int B_RPT_INH = 2;
  localparam int B_PD_EN = 3;
  localparam int B_LPC_EN = 4;
  localparam int B_EN_POL = 5;
  localparam int B_OC_EN = 6;
  localparam int B_OP_EN = 7;
  localparam int B_UP_EN = 8;
  localparam int B_APC_EN = 9;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h226;

  // fault pin configuration bits
  localparam int B_FPOL = 0;
  localparam int B_FDRV = 1;
  localparam int B_FOVR = 3;
  localparam int B_FFORCE = 4;
  localparam int FCFG_W = 5;
  localparam logic [FCFG_W-1:0] FCFG_RST = 5'h01;

  // user result layout on read, selector on write; fault status flag bits
  localparam int B_UVALID = 15;
  localparam int B_USRC = 10;
  localparam int B_STAT_TX = 8;
  localparam int B_STAT_LOCK = 9;

  typedef enum logic [1:0] {DRV_OPEN, DRV_WEAK, DRV_STRONG, DRV_PUSH} ltfac_drv_type;

  // converter input codes; 2 is the laser voltage
  localparam logic [2:0] SRC_IS = 3'h0;
  localparam logic [2:0] SRC_IM = 3'h1;
  localparam logic [2:0] SRC_VLD = 3'h2;
  localparam logic [2:0] SRC_IMD = 3'h3;
  localparam logic [2:0] SRC_VTERM = 3'h4;
  localparam logic [2:0] SRC_TEMP = 3'h5;

  // fault status codes, 1 is the highest priority
  localparam logic [2:0] FC_NONE = 3'h0;
  localparam logic [2:0] FC_UV = 3'h1;
  localparam logic [2:0] FC_MEM = 3'h2;
  localparam logic [2:0] FC_UP = 3'h3;
  localparam logic [2:0] FC_OP = 3'h4;
  localparam logic [2:0] FC_OC = 3'h5;
endpackage : ltfac_pkg

// File: ltfac_adc_if.sv
// slot schedule signals between the controller and its converter scheduler
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ltfac_adc_if;
  logic [1:0] slot;
  logic       done;
  logic [2:0] mux_sel;
  logic [2:0] user_sel;
  logic       apc_mode;
  modport sched (output slot, output done, output mux_sel, input user_sel, input apc_mode);
  modport ctrl (input slot, input done, input mux_sel, output user_sel, output apc_mode);
endinterface : ltfac_adc_if

// File: ltfac_sched.sv
// four-slot conversion scheduler, one slot per conversion time
// assumes the converter samples mux_sel for the whole slot
`timescale 1ns/1ps
module ltfac_sched
  import ltfac_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC
)(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  ltfac_adc_if.sched  adc
);
  typedef enum logic [1:0] {SL_TEMP, SL_MOD, SL_LOOP, SL_USER} ltfac_slot_type;

  ltfac_slot_type    slot_r;
  logic [31:0]       cnt_r;
  logic [2:0]        usel_r;
  logic              last;
  logic [2:0]        sel;

  assign last = (cnt_r == 32'(CONV_CYCLES - 1));
  assign adc.done = last; // [R13]
  assign adc.slot = slot_r;
  assign adc.mux_sel = sel;

  always_comb
  begin
    case (slot_r)
      SL_TEMP: sel = SRC_TEMP; // [R14]
      SL_MOD:  sel = SRC_IM;
      SL_LOOP: sel = adc.apc_mode ? SRC_IMD : SRC_IS;
      SL_USER: sel = usel_r; // [R17]
      default: sel = SRC_TEMP;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      slot_r <= SL_TEMP;
      usel_r <= SRC_IS;
    end
    else
    begin
      cnt_r <= last ? '0 : cnt_r + 32'h1;
      if (last)
        slot_r <= ltfac_slot_type'(slot_r + 2'h1); // [R13]
      // selector is frozen for a whole user slot
      if (last && slot_r == SL_LOOP)
        usel_r <= adc.user_sel;
    end
  end
endmodule : ltfac_sched

// File: ltfac_fltpin.sv
// fault pin driver: polarity, drive style and software override
// assumes the pad applies the pull-up enables and tri-states on oe low
`timescale 1ns/1ps
module ltfac_fltpin
  import ltfac_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              fault_ind,
  input  wire logic [FCFG_W-1:0] cfg,
  output logic                   pin_o,
  output logic                   pin_oe,
  output logic                   pull_weak,
  output logic                   pull_strong
);
  logic          asserted;
  logic          level;
  ltfac_drv_type mode;

  assign asserted = cfg[B_FOVR] ? cfg[B_FFORCE] : fault_ind; // [R9]
  assign level = cfg[B_FPOL] ? asserted : ~asserted; // [R7]
  assign mode = ltfac_drv_type'(cfg[B_FDRV +: 2]);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
      pull_weak <= 1'b0;
      pull_strong <= 1'b0;
    end
    else
    begin
      // pull-up styles only ever pull low actively
      pin_o <= (mode == DRV_PUSH) ? level : 1'b0; // [R8]
      pin_oe <= (mode == DRV_PUSH) | ~level;
      pull_weak <= (mode == DRV_WEAK);
      pull_strong <= (mode == DRV_STRONG);
    end
  end
endmodule : ltfac_fltpin

// File: ltfac_top.sv
// laser transmitter fault, enable, converter and current control
// Summary of operation
// [R1] auto-shutdown set: any enabled fault disables the transmitter at once
// [R2] auto-shutdown clear: soft fault keeps transmitting until host disables
// [R3] undervoltage and memory-load failure always disable the transmitter
// [R4] first latched soft fault clears when the transmitter is disabled
// [R5] second fault within 25 ms of re-enable locks the transmitter off
// [R6] lockout suppressed while the repeated-fault-inhibit bit is zero
// [R7] fault pin active level chosen by a polarity bit
// [R8] two-bit drive mode picks open drain, weak, strong pull-up or push-pull
// [R9] override bit hands the fault pin to the force bit alone
// [R10] power-down bit plus disabled transmitter switches off high-speed amplifiers
// [R11] five-bit boost setting, smaller code gives stronger falling-edge boost
// [R12] ten-bit results from a six-input multiplexer
// [R13] each conversion lasts 1 ms, four slots repeat endlessly
// [R14] slots: temperature, modulation, monitor or source current, user choice
// [R15] compensation, servo and current updates happen in the user slot
// [R16] slot-three result shares one register whatever the loop mode
// [R17] host picks user input with three-bit selector, code 2 is laser voltage
// [R18] user conversion end stores data, sets valid, records converted source
// [R19] any user register access clears valid until next user conversion
// [R20] reported source names the converted input, not the latest selector
// [R21] user register writes a selector but reads back result layout
// [R22] power loop off lets host write source and modulation currents
// [R23] transmit only while enable pin and software enable are both active
// [R24] highest-priority simultaneous fault latched in status, cleared on read
// [R25] after reset user valid is clear and lockout released
// assumes cmd_* is a decoded serial-bus transfer, one cycle per access,
// and that converter result and servo codes are on this clock
`timescale 1ns/1ps
module ltfac_top
  import ltfac_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYC,
  parameter int LOCK_CYCLES = LOCK_CYC
)(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire logic [7:0]           cmd_code,
  input  wire logic [15:0]          cmd_wdata,
  output logic [15:0]               cmd_rdata,
  input  wire logic                 en_pin,
  input  wire logic                 oc_det,
  input  wire logic                 op_det,
  input  wire logic                 up_det,
  input  wire logic                 uv_det,
  input  wire logic                 mem_load_fail,
  input  wire logic [ltfac_pkg::ADC_W-1:0] adc_result,
  input  wire logic [ltfac_pkg::ADC_W-1:0] servo_src_code,
  input  wire logic [ltfac_pkg::ADC_W-1:0] servo_mod_code,
  output logic [2:0]                adc_mux_sel,
  output logic                      comp_update,
  output logic                      tx_enable,
  output logic                      hs_amp_pd,
  output logic [ltfac_pkg::BOOST_W-1:0] falling_edge_boost,
  output logic [ltfac_pkg::ADC_W-1:0] source_current_dac,
  output logic [ltfac_pkg::ADC_W-1:0] modulation_current_dac,
  output logic                      fault_o,
  output logic                      fault_oe,
  output logic                      fault_pull_weak,
  output logic                      fault_pull_strong
);
  import ltfac_pkg::*;

  function automatic logic hit(input logic [7:0] code, input logic [7:0] want);
    hit = (code == want);
  endfunction : hit

  ltfac_adc_if adc ();

  // external levels pass two flops before use
  logic [5:0]       sync1_r;
  logic [5:0]       sync2_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [FCFG_W-1:0] fcfg_r;
  logic [2:0]       stat_r;
  logic [2:0]       stat_nxt;
  logic [2:0]       user_sel_r;
  logic [ADC_W-1:0] temp_r;
  logic [ADC_W-1:0] mod_res_r;
  logic [ADC_W-1:0] slot3_r;
  logic [ADC_W-1:0] user_data_r;
  logic [2:0]       user_src_r;
  logic [2:0]       conv_src_r;
  logic             user_valid_r;
  logic             soft_flt_r;
  logic             armed_r;
  logic             lock_r;
  logic             tx_req_d_r;
  logic [31:0]      win_r;
  logic [4:0]       det_d_r;
  logic [ADC_W-1:0] src_dac_r;
  logic [ADC_W-1:0] mod_dac_r;
  logic [BOOST_W-1:0] boost_r;

  logic en_s, oc_s, op_s, up_s, uv_s, mem_s;
  assign {mem_s, uv_s, up_s, op_s, oc_s, en_s} = sync2_r;

  wire wr = cmd_valid & cmd_write;
  wire rd = cmd_valid & ~cmd_write;
  wire wr_ctrl = wr & hit(cmd_code, CMD_CTRL);
  wire wr_fcfg = wr & hit(cmd_code, CMD_FLT_CFG);
  wire wr_boost = wr & hit(cmd_code, CMD_BOOST);
  wire wr_user = wr & hit(cmd_code, CMD_USER);
  wire wr_sdac = wr & hit(cmd_code, CMD_SRC_DAC);
  wire wr_mdac = wr & hit(cmd_code, CMD_MOD_DAC);
  wire rd_stat = rd & hit(cmd_code, CMD_FLT_STAT);
  wire acc_user = cmd_valid & hit(cmd_code, CMD_USER);

  wire apc = ctrl_r[B_APC_EN];
  wire lpc = ctrl_r[B_LPC_EN];
  wire en_act = (en_s == ctrl_r[B_EN_POL]);
  wire tx_req = en_act & ctrl_r[B_SOFT_EN]; // [R23]
  wire hard = uv_s | mem_s; // [R3]
  wire oc_q = oc_s & ctrl_r[B_OC_EN];
  wire op_q = op_s & ctrl_r[B_OP_EN] & apc;
  wire up_q = up_s & ctrl_r[B_UP_EN] & apc;
  wire soft_det = oc_q | op_q | up_q;
  wire lock_eff = lock_r & ctrl_r[B_RPT_INH]; // [R6]
  wire auto_off = soft_flt_r & ctrl_r[B_AUTO_SD]; // [R1] [R2]
  wire tx_on = tx_req & ~hard & ~lock_eff & ~auto_off; // [R3]
  wire win_open = (win_r != 32'h0);
  wire re_enable = tx_req & ~tx_req_d_r;

  wire [4:0] det_now = {oc_q, op_q, up_q, mem_s, uv_s};
  wire [4:0] rise = det_now & ~det_d_r;

  wire slot_done = adc.done;
  wire user_done = slot_done & (adc.slot == 2'h3);

  assign adc.user_sel = user_sel_r;
  assign adc.apc_mode = apc;
  assign adc_mux_sel = adc.mux_sel; // [R12]
  assign comp_update = user_done; // [R15]
  assign tx_enable = tx_on;
  assign hs_amp_pd = ctrl_r[B_PD_EN] & ~tx_on; // [R10]
  assign falling_edge_boost = boost_r; // [R11]
  assign source_current_dac = src_dac_r;
  assign modulation_current_dac = mod_dac_r;

  // highest priority rising cause, code 1 wins
  logic [2:0] new_code;
  always_comb
  begin
    new_code = FC_NONE;
    if (rise[0])
      new_code = FC_UV;
    else if (rise[1])
      new_code = FC_MEM;
    else if (rise[2])
      new_code = FC_UP;
    else if (rise[3])
      new_code = FC_OP;
    else if (rise[4])
      new_code = FC_OC;
  end

  // a new cause in the reading cycle survives the clear
  wire stat_take = (new_code != FC_NONE) &&
                   (rd_stat || stat_r == FC_NONE || new_code < stat_r);
  assign stat_nxt = stat_take ? new_code : (rd_stat ? FC_NONE : stat_r); // [R24]

  // read data mux, user register reads in result layout
  logic [15:0] rmux;
  always_comb
  begin
    case (cmd_code)
      CMD_CTRL:     rmux = 16'(ctrl_r);
      CMD_FLT_CFG:  rmux = 16'(fcfg_r);
      CMD_FLT_STAT: rmux = {6'h00, lock_eff, tx_on, 5'h00, stat_r};
      CMD_BOOST:    rmux = 16'(boost_r);
      CMD_TEMP:     rmux = 16'(temp_r);
      CMD_MOD_RES:  rmux = 16'(mod_res_r);
      CMD_SLOT3:    rmux = 16'(slot3_r); // [R16]
      CMD_USER:     rmux = {user_valid_r, 2'h0, user_src_r, user_data_r}; // [R21]
      CMD_SRC_DAC:  rmux = 16'(src_dac_r);
      CMD_MOD_DAC:  rmux = 16'(mod_dac_r);
      default:      rmux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      cmd_rdata <= 16'h0000;
    end
    else
    begin
      sync1_r <= {mem_load_fail, uv_det, up_det, op_det, oc_det, en_pin};
      sync2_r <= sync1_r;
      if (rd)
        cmd_rdata <= rmux;
    end
  end

  // host writable configuration
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_r <= CTRL_RST;
      fcfg_r <= FCFG_RST;
      boost_r <= '0;
      user_sel_r <= SRC_IS;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= cmd_wdata[CTRL_W-1:0];
      if (wr_fcfg)
        fcfg_r <= cmd_wdata[FCFG_W-1:0];
      if (wr_boost)
        boost_r <= cmd_wdata[BOOST_W-1:0];
      if (wr_user)
        user_sel_r <= cmd_wdata[2:0]; // [R17] [R21]
    end
  end

  // fault latching, repeated-fault window and lockout
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      soft_flt_r <= 1'b0;
      armed_r <= 1'b0;
      lock_r <= 1'b0; // [R25]
      tx_req_d_r <= 1'b0;
      win_r <= '0;
      det_d_r <= '0;
      stat_r <= FC_NONE;
    end
    else
    begin
      tx_req_d_r <= tx_req;
      det_d_r <= det_now;
      stat_r <= stat_nxt;
      if (!tx_req)
        soft_flt_r <= 1'b0; // [R4]
      else if (soft_det && tx_on)
        soft_flt_r <= 1'b1;
      if (soft_flt_r && !tx_req)
        armed_r <= 1'b1;
      else if (armed_r && tx_req && !win_open && !re_enable)
        armed_r <= 1'b0;
      if (re_enable && armed_r)
        win_r <= 32'(LOCK_CYCLES); // [R5]
      else if (!tx_req)
        win_r <= '0;
      else if (win_open)
        win_r <= win_r - 32'h1;
      // only a reset releases the lock
      if (armed_r && win_open && soft_det)
        lock_r <= 1'b1; // [R5]
    end
  end

  // converter results, user slot handshake and current outputs
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      temp_r <= '0;
      mod_res_r <= '0;
      slot3_r <= '0;
      user_data_r <= '0;
      user_src_r <= SRC_IS;
      conv_src_r <= SRC_IS;
      user_valid_r <= 1'b0; // [R25]
      src_dac_r <= '0;
      mod_dac_r <= '0;
    end
    else
    begin
      if (adc.slot == 2'h3)
        conv_src_r <= adc.mux_sel;
      if (slot_done && adc.slot == 2'h0)
        temp_r <= adc_result;
      if (slot_done && adc.slot == 2'h1)
        mod_res_r <= adc_result;
      if (slot_done && adc.slot == 2'h2)
        slot3_r <= adc_result; // [R16]
      if (user_done)
      begin
        user_data_r <= adc_result; // [R18]
        user_src_r <= conv_src_r; // [R20]
      end
      // completion wins over a same-cycle access
      if (user_done)
        user_valid_r <= 1'b1; // [R18]
      else if (acc_user)
        user_valid_r <= 1'b0; // [R19]
      if (lpc && user_done)
      begin
        src_dac_r <= servo_src_code; // [R15]
        mod_dac_r <= servo_mod_code;
      end
      else if (!lpc)
      begin
        if (wr_sdac)
          src_dac_r <= cmd_wdata[ADC_W-1:0]; // [R22]
        if (wr_mdac)
          mod_dac_r <= cmd_wdata[ADC_W-1:0];
      end
    end
  end

  ltfac_sched #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_sched (
    .clk     (clk),
    .sys_rst (sys_rst),
    .adc     (adc.sched)
  );

  ltfac_fltpin u_fltpin (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .fault_ind   (soft_flt_r | uv_s | mem_s | lock_eff),
    .cfg         (fcfg_r),
    .pin_o       (fault_o),
    .pin_oe      (fault_oe),
    .pull_weak   (fault_pull_weak),
    .pull_strong (fault_pull_strong)
  );
endmodule : ltfac_top

// File: ltfac_assertions.sv
// concurrent checks on the transmitter controller top ports
// assumes binding into ltfac_top with the same slot length
`timescale 1ns/1ps
module ltfac_assertions #(
  parameter int CONV_CYCLES = ltfac_pkg::CONV_CYC
)(
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire logic                          cmd_valid,
  input wire logic                          cmd_write,
  input wire logic [7:0]                    cmd_code,
  input wire logic [15:0]                   cmd_wdata,
  input wire logic [15:0]                   cmd_rdata,
  input wire logic                          en_pin,
  input wire logic                          oc_det,
  input wire logic                          op_det,
  input wire logic                          up_det,
  input wire logic                          uv_det,
  input wire logic                          mem_load_fail,
  input wire logic [ltfac_pkg::ADC_W-1:0]   adc_result,
  input wire logic [ltfac_pkg::ADC_W-1:0]   servo_src_code,
  input wire logic [ltfac_pkg::ADC_W-1:0]   servo_mod_code,
  input wire logic [2:0]                    adc_mux_sel,
  input wire logic                          comp_update,
  input wire logic                          tx_enable,
  input wire logic                          hs_amp_pd,
  input wire logic [ltfac_pkg::BOOST_W-1:0] falling_edge_boost,
  input wire logic [ltfac_pkg::ADC_W-1:0]   source_current_dac,
  input wire logic [ltfac_pkg::ADC_W-1:0]   modulation_current_dac,
  input wire logic                          fault_o,
  input wire logic                          fault_oe,
  input wire logic                          fault_pull_weak,
  input wire logic                          fault_pull_strong
);
  import ltfac_pkg::*;
  localparam int PERIOD = 4 * CONV_CYCLES - 1;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        seen_r;
  // cycles since the last user slot ended
  assign cnt_nxt = comp_update ? 32'h0 : cnt_r + 32'h1;
  always_ff @(posedge clk)
  begin
    cnt_r  <= sys_rst ? 32'h0 : cnt_nxt;
    seen_r <= sys_rst ? 1'b0 : (seen_r | comp_update);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // four samples so the input synchroniser has caught up
  sequence s_uv_held; uv_det [*4]; endsequence
  sequence s_mem_held; mem_load_fail [*4]; endsequence
  a_uv_blocks_tx: assert property (s_uv_held |-> !tx_enable)
    else $error("tx on during undervoltage");
  a_mem_blocks_tx: assert property (s_mem_held |-> !tx_enable)
    else $error("tx on during memory load failure");
  a_pd_when_off: assert property (hs_amp_pd |-> !tx_enable)
    else $error("amplifiers off while transmitting");
  a_comp_single: assert property (comp_update |=> !comp_update)
    else $error("update pulse longer than one cycle");
  a_slot_period: assert property (seen_r && comp_update |-> cnt_r == PERIOD)
    else $error("slot cycle length wrong");
  a_slot_temp: assert property (comp_update |=> adc_mux_sel == SRC_TEMP)
    else $error("first slot not temperature");
  a_slot_mod: assert property (seen_r && cnt_r == CONV_CYCLES |-> adc_mux_sel == SRC_IM)
    else $error("second slot not modulation current");
  a_pull_low_only: assert property (fault_pull_weak || fault_pull_strong |-> !(fault_oe && fault_o))
    else $error("pull-up mode drives high");
  a_boost_by_write: assert property (!$stable(falling_edge_boost) |->
    $past(cmd_valid && cmd_write && cmd_code == CMD_BOOST))
    else $error("boost changed without a write");
  a_dac_by_cause: assert property (!$stable(source_current_dac) |->
    $past(cmd_valid && cmd_write) || $past(comp_update) || $past(comp_update, 2))
    else $error("source dac changed without cause");
endmodule : ltfac_assertions

bind ltfac_top ltfac_assertions #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.*);

// File: ltfac_afe_model.sv
// analog front end seen by the controller: converter and servo math
// assumes results are tagged with the converted input for easy checking
`timescale 1ns/1ps
module ltfac_afe_model (
  input  wire logic [2:0]                  adc_mux_sel,
  output logic      [ltfac_pkg::ADC_W-1:0] adc_result,
  output logic      [ltfac_pkg::ADC_W-1:0] servo_src_code,
  output logic      [ltfac_pkg::ADC_W-1:0] servo_mod_code
);
  import ltfac_pkg::*;
  // upper bits name the input, so a wrong slot shows in the data
  assign adc_result     = {adc_mux_sel, 7'h2A};
  assign servo_src_code = 10'h1A5;
  assign servo_mod_code = 10'h0C3;
endmodule : ltfac_afe_model

// File: ltfac_tb_top.sv
// self-checking bench for the transmitter controller
// assumes the front-end model tags results with the converted input
`timescale 1ns/1ps
module ltfac_tb_top;
  import ltfac_pkg::*;
  logic               clk           = 1'b0;
  logic               sys_rst       = 1'b1;
  logic               cmd_valid     = 1'b0;
  logic               cmd_write     = 1'b0;
  logic [7:0]         cmd_code      = 8'h00;
  logic [15:0]        cmd_wdata     = 16'h0000;
  logic               en_pin        = 1'b0;
  logic               oc_det        = 1'b0;
  logic               op_det        = 1'b0;
  logic               up_det        = 1'b0;
  logic               uv_det        = 1'b0;
  logic               mem_load_fail = 1'b0;
  logic [15:0]        cmd_rdata;
  logic [15:0]        rd;
  logic [ADC_W-1:0]   adc_result;
  logic [ADC_W-1:0]   servo_src_code;
  logic [ADC_W-1:0]   servo_mod_code;
  logic [2:0]         adc_mux_sel;
  logic               comp_update;
  logic               tx_enable;
  logic               hs_amp_pd;
  logic [BOOST_W-1:0] falling_edge_boost;
  logic [ADC_W-1:0]   source_current_dac;
  logic [ADC_W-1:0]   modulation_current_dac;
  logic               fault_o;
  logic               fault_oe;
  logic               fault_pull_weak;
  logic               fault_pull_strong;
  int                 err_count     = 0;
  int                 checked       = 0;
  int                 cyc           = 0;

  ltfac_top #(.CONV_CYCLES(20), .LOCK_CYCLES(200)) i_dut (.*);
  ltfac_afe_model i_afe (.*);

  always #25 clk = ~clk;

  task automatic summarize;
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // a hang must still end in the verdict
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    tick(1);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = c;
    cmd_wdata = d;
    tick(1);
    cmd_valid = 1'b0;
    rd        = cmd_rdata;
  endtask : acc

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic chkp(input string n, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : chkp

  // waits for the end of a user slot, then lets the valid flag land
  task automatic wcomp;
    int k = 0;
    while (comp_update !== 1'b1 && k < 200)
    begin
      tick(1);
      k++;
    end
    if (k == 200)
      chkp("comp_update", 1'b1, 1'b0);
    tick(3);
  endtask : wcomp

  function automatic logic [15:0] uw(input logic v, input logic [2:0] s);
    return {v, 2'b00, s, s, 7'h2A};
  endfunction : uw

  initial
  begin
    tick(6);
    sys_rst = 1'b0;
    acc(1'b0, CMD_CTRL, 16'h0000);
    chk("ctrl", 16'h0226, rd);
    acc(1'b0, CMD_USER, 16'h0000);
    chkp("valid", 1'b0, rd[15]);
    en_pin = 1'b1;
    tick(4);
    chkp("tx", 1'b0, tx_enable);
    acc(1'b1, CMD_CTRL, 16'h02EF);
    tick(4);
    chkp("tx", 1'b1, tx_enable);
    chkp("pd", 1'b0, hs_amp_pd);
    en_pin = 1'b0;
    tick(4);
    chkp("tx", 1'b0, tx_enable);
    chkp("pd", 1'b1, hs_amp_pd);
    en_pin = 1'b1;
    acc(1'b1, CMD_CTRL, 16'h02E7);
    op_det = 1'b1;
    oc_det = 1'b1;
    tick(4);
    op_det = 1'b0;
    oc_det = 1'b0;
    tick(4);
    chkp("tx", 1'b0, tx_enable);
    chkp("pin_oe", 1'b0, fault_oe);
    acc(1'b0, CMD_FLT_STAT, 16'h0000);
    chk("status", {13'h0000, FC_OP}, {13'h0000, rd[2:0]});
    acc(1'b0, CMD_FLT_STAT, 16'h0000);
    chk("status", 16'h0000, {13'h0000, rd[2:0]});
    acc(1'b1, CMD_FLT_CFG, 16'h0007);
    tick(3);
    chkp("pin", 1'b1, fault_o);
    chkp("pin_oe", 1'b1, fault_oe);
    acc(1'b1, CMD_FLT_CFG, 16'h0006);
    tick(3);
    chkp("pin", 1'b0, fault_o);
    acc(1'b1, CMD_FLT_CFG, 16'h000F);
    tick(3);
    chkp("pin", 1'b0, fault_o);
    acc(1'b1, CMD_FLT_CFG, 16'h001F);
    tick(3);
    chkp("pin", 1'b1, fault_o);
    acc(1'b1, CMD_FLT_CFG, 16'h0003);
    tick(3);
    chkp("weak", 1'b1, fault_pull_weak);
    acc(1'b1, CMD_FLT_CFG, 16'h0005);
    tick(3);
    chkp("strong", 1'b1, fault_pull_strong);
    en_pin = 1'b0;
    tick(4);
    en_pin = 1'b1;
    tick(4);
    chkp("tx", 1'b1, tx_enable);
    oc_det = 1'b1;
    tick(4);
    oc_det = 1'b0;
    en_pin = 1'b0;
    tick(4);
    en_pin = 1'b1;
    tick(4);
    chkp("tx", 1'b0, tx_enable);
    acc(1'b0, CMD_FLT_STAT, 16'h0000);
    chkp("lock", 1'b1, rd[9]);
    acc(1'b1, CMD_CTRL, 16'h02E3);
    tick(4);
    chkp("tx", 1'b1, tx_enable);
    sys_rst = 1'b1;
    tick(6);
    sys_rst = 1'b0;
    acc(1'b0, CMD_FLT_STAT, 16'h0000);
    chkp("lock", 1'b0, rd[9]);
    acc(1'b1, CMD_CTRL, 16'h02E5);
    oc_det = 1'b1;
    tick(4);
    oc_det = 1'b0;
    tick(4);
    chkp("tx", 1'b1, tx_enable);
    for (int i = 0; i < 2; i++)
    begin
      uv_det = (i == 0);
      mem_load_fail = (i == 1);
      tick(5);
      chkp("tx", 1'b0, tx_enable);
      uv_det = 1'b0;
      mem_load_fail = 1'b0;
      tick(5);
      chkp("tx", 1'b1, tx_enable);
    end
    acc(1'b1, CMD_BOOST, 16'h0005);
    acc(1'b0, CMD_BOOST, 16'h0000);
    chk("boost", 16'h0005, {11'h000, falling_edge_boost});
    chk("boost_rd", 16'h0005, rd);
    acc(1'b1, CMD_SRC_DAC, 16'h0123);
    acc(1'b1, CMD_MOD_DAC, 16'h0321);
    tick(1);
    chk("src_dac", 16'h0123, {6'h00, source_current_dac});
    chk("mod_dac", 16'h0321, {6'h00, modulation_current_dac});
    acc(1'b1, CMD_CTRL, 16'h02F5);
    acc(1'b1, CMD_SRC_DAC, 16'h00AA);
    tick(1);
    chk("src_dac", 16'h0123, {6'h00, source_current_dac});
    wcomp();
    chk("src_dac", 16'h01A5, {6'h00, source_current_dac});
    chk("mod_dac", 16'h00C3, {6'h00, modulation_current_dac});
    acc(1'b1, CMD_USER, {13'h0000, SRC_VLD});
    acc(1'b0, CMD_TEMP, 16'h0000);
    chk("temp", {6'h00, SRC_TEMP, 7'h2A}, rd);
    acc(1'b0, CMD_MOD_RES, 16'h0000);
    chk("mod", {6'h00, SRC_IM, 7'h2A}, rd);
    acc(1'b0, CMD_SLOT3, 16'h0000);
    chk("slot3", {6'h00, SRC_IMD, 7'h2A}, rd);
    wcomp();
    acc(1'b0, CMD_USER, 16'h0000);
    chk("user", uw(1'b1, SRC_VLD), rd);
    acc(1'b1, CMD_USER, {13'h0000, SRC_VTERM});
    acc(1'b0, CMD_USER, 16'h0000);
    chk("user", uw(1'b0, SRC_VLD), rd);
    for (int s = 0; s < 6; s++)
    begin
      acc(1'b1, CMD_USER, {13'h0000, 3'(s)});
      wcomp();
      wcomp();
      acc(1'b0, CMD_USER, 16'h0000);
      chk("user", uw(1'b1, 3'(s)), rd);
      acc(1'b0, CMD_USER, 16'h0000);
      chkp("valid", 1'b0, rd[15]);
    end
    acc(1'b1, CMD_CTRL, 16'h00F5);
    wcomp();
    wcomp();
    acc(1'b0, CMD_SLOT3, 16'h0000);
    chk("slot3", {6'h00, SRC_IS, 7'h2A}, rd);
    acc(1'b1, CMD_USER, 16'h0000);
    acc(1'b0, CMD_USER, 16'h0000);
    chkp("valid", 1'b0, rd[15]);
    summarize();
  end
endmodule : ltfac_tb_top
